// ==== logic/tpc_top.sv ====
`timescale 1ns/1ns
module tpc_top (
  input  wire logic                            i_core_clk,
  input  wire logic                            i_rst,
  input  wire logic                            i_copro_rst_n,
  input  wire logic                            i_scl,
  input  wire logic                            i_sda,
  output logic                                 o_sda,
  output logic                                 o_sda_oe,
  output logic                                 o_attn_n,
  output logic                                 o_led_attn,
  output logic                                 o_led_rst,
  output logic                                 o_led_scl,
  output logic                                 o_led_sda,
  output logic [tpc_pkg::NUM_CHANNELS-1:0]     o_pwm
);
  localparam int unsigned NCH = tpc_pkg::NUM_CHANNELS;

  tpc_pkg::tpc_state_t state_reg;
  tpc_pkg::tpc_state_t state_next;

  logic             rst_int;
  logic             scl_d_reg;
  logic             sda_d_reg;
  logic [3:0]       bit_reg;
  logic [7:0]       shift_reg;
  logic [7:0]       tx_reg;
  logic [7:0]       ptr_reg;
  logic             rw_reg;
  logic             first_reg;
  logic             nack_reg;
  logic             oe_reg;
  logic             attn_reg;
  logic [NCH-1:0]   en_reg;
  logic [1:0]       div_reg  [NCH];
  logic [7:0]       per_reg  [NCH];
  logic [9:0]       wid_reg  [NCH];
  logic [NCH-1:0]   applied;
  logic [7:0]       mem_q;
  logic [7:0]       cfg_q;

  // the pin reset and the system reset both return the block to its start
  assign rst_int = i_rst || !i_copro_rst_n;

  function automatic logic loc_is_cfg(input logic [7:0] loc);
    loc_is_cfg = (loc < tpc_pkg::LOC_STATUS);
  endfunction

  function automatic logic [1:0] loc_chan(input logic [7:0] loc);
    loc_chan = loc[3:2];
  endfunction

  // program memory occupies one whole sixteen-location page
  function automatic logic loc_is_mem(input logic [7:0] loc);
    loc_is_mem = (loc[7:4] == tpc_pkg::LOC_MEM_BASE[7:4]);
  endfunction

  // bus conditions; pins are taken as synchronous to the core clock
  wire start_cond = i_scl && scl_d_reg && sda_d_reg && !i_sda;
  wire stop_cond  = i_scl && scl_d_reg && !sda_d_reg && i_sda;
  wire scl_rise   = i_scl && !scl_d_reg;
  wire scl_fall   = !i_scl && scl_d_reg;
  wire byte_done  = scl_fall && (bit_reg == 4'h8);
  wire addr_match = (shift_reg[7:1] == tpc_pkg::TARGET_ADDR);

  // only the clocks of a byte phase are counted: the acknowledge clock must
  // stay out of the shifter, or every following byte would slip by one bit
  wire in_byte    = (state_reg == tpc_pkg::TPC_ADDR) ||
                    (state_reg == tpc_pkg::TPC_WR_BYTE) ||
                    (state_reg == tpc_pkg::TPC_RD_BYTE);

  // a data byte after the pointer byte is a location write
  wire       wr_strobe = (state_reg == tpc_pkg::TPC_WR_BYTE) && byte_done && !first_reg;
  wire       wr_cfg    = wr_strobe && loc_is_cfg(ptr_reg);
  wire       wr_mem    = wr_strobe && loc_is_mem(ptr_reg);
  wire [1:0] wr_ch     = loc_chan(ptr_reg);
  wire [1:0] wr_fld    = ptr_reg[1:0];

  // a byte is loaded for transmit at the end of an acknowledge in read mode
  wire tx_load = scl_fall &&
                 (((state_reg == tpc_pkg::TPC_ADDR_ACK) && rw_reg) ||
                  ((state_reg == tpc_pkg::TPC_RD_ACK) && !nack_reg));
  wire [7:0] rd_data   = loc_is_mem(ptr_reg) ? mem_q : cfg_q;
  wire       stat_read = tx_load && (ptr_reg == tpc_pkg::LOC_STATUS);

  // read multiplexer over channel settings and status
  always_comb begin
    cfg_q = 8'h00;
    if (ptr_reg == tpc_pkg::LOC_STATUS) begin
      cfg_q[tpc_pkg::STAT_ATTN_BIT] = attn_reg;
      cfg_q[tpc_pkg::STAT_OUT_LSB +: NCH] = o_pwm;
    end else if (loc_is_cfg(ptr_reg) && (loc_chan(ptr_reg) < NCH)) begin
      case (ptr_reg[1:0])
        tpc_pkg::LOC_CTRL: begin
          cfg_q[tpc_pkg::CTRL_EN_BIT] = en_reg[loc_chan(ptr_reg)];
          cfg_q[tpc_pkg::CTRL_DIV_LSB +: 2] = div_reg[loc_chan(ptr_reg)];
        end
        tpc_pkg::LOC_PERIOD:   cfg_q = per_reg[loc_chan(ptr_reg)];
        tpc_pkg::LOC_WIDTH_LO: cfg_q = wid_reg[loc_chan(ptr_reg)][7:0];
        default:               cfg_q = {6'h00, wid_reg[loc_chan(ptr_reg)][9:8]};
      endcase
    end
  end

  // transaction sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tpc_pkg::TPC_IDLE:     state_next = tpc_pkg::TPC_IDLE;
      tpc_pkg::TPC_ADDR: begin
        if (byte_done) begin
          state_next = addr_match ? tpc_pkg::TPC_ADDR_ACK : tpc_pkg::TPC_IDLE;
        end
      end
      tpc_pkg::TPC_ADDR_ACK: begin
        if (scl_fall) begin
          state_next = rw_reg ? tpc_pkg::TPC_RD_BYTE : tpc_pkg::TPC_WR_BYTE;
        end
      end
      tpc_pkg::TPC_WR_BYTE: begin
        if (byte_done) begin
          state_next = tpc_pkg::TPC_WR_ACK;
        end
      end
      tpc_pkg::TPC_WR_ACK: begin
        if (scl_fall) begin
          state_next = tpc_pkg::TPC_WR_BYTE;
        end
      end
      tpc_pkg::TPC_RD_BYTE: begin
        if (byte_done) begin
          state_next = tpc_pkg::TPC_RD_ACK;
        end
      end
      tpc_pkg::TPC_RD_ACK: begin
        if (scl_fall) begin
          state_next = nack_reg ? tpc_pkg::TPC_IDLE : tpc_pkg::TPC_RD_BYTE;
        end
      end
      default:               state_next = tpc_pkg::TPC_IDLE;
    endcase
    // start and stop override any state, so a repeated start works anywhere
    if (start_cond) begin
      state_next = tpc_pkg::TPC_ADDR;
    end else if (stop_cond) begin
      state_next = tpc_pkg::TPC_IDLE;
    end
  end

  // line history starts idle-high so leaving reset never looks like a start
  always_ff @(posedge i_core_clk) begin
    if (rst_int) begin
      state_reg <= tpc_pkg::TPC_IDLE;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      scl_d_reg <= i_scl;
      sda_d_reg <= i_sda;
    end
  end

  // bit counter and receive shifter
  always_ff @(posedge i_core_clk) begin
    if (rst_int || start_cond) begin
      bit_reg   <= 4'h0;
      shift_reg <= 8'h00;
    end else if (scl_rise && in_byte && (bit_reg != 4'h8)) begin
      bit_reg   <= bit_reg + 4'h1;
      shift_reg <= {shift_reg[6:0], i_sda};
    end else if (scl_fall && (bit_reg == 4'h8)) begin
      bit_reg   <= 4'h0;
    end
  end

  // direction, pointer-phase and master acknowledge capture
  always_ff @(posedge i_core_clk) begin
    if (rst_int) begin
      rw_reg    <= 1'b0;
      first_reg <= 1'b0;
      nack_reg  <= 1'b0;
    end else begin
      if ((state_reg == tpc_pkg::TPC_ADDR) && byte_done) begin
        rw_reg    <= shift_reg[0];
        first_reg <= 1'b1;
      end else if ((state_reg == tpc_pkg::TPC_WR_BYTE) && byte_done) begin
        first_reg <= 1'b0;
      end
      if ((state_reg == tpc_pkg::TPC_RD_ACK) && scl_rise) begin
        nack_reg <= i_sda;
      end
    end
  end

  // location pointer: set by the first written byte, advanced per data byte
  always_ff @(posedge i_core_clk) begin
    if (rst_int) begin
      ptr_reg <= 8'h00;
    end else if ((state_reg == tpc_pkg::TPC_WR_BYTE) && byte_done && first_reg) begin
      ptr_reg <= shift_reg;
    end else if (wr_strobe || tx_load) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // open-drain data line: drive low for acknowledge and for zero bits
  always_ff @(posedge i_core_clk) begin
    if (rst_int || start_cond || stop_cond) begin
      oe_reg <= 1'b0;
      tx_reg <= 8'hff;
    end else if (tx_load) begin
      tx_reg <= rd_data;
      oe_reg <= !rd_data[7];
    end else if (byte_done && (state_reg == tpc_pkg::TPC_RD_BYTE)) begin
      oe_reg <= 1'b0;
    end else if (byte_done && addr_match && (state_reg == tpc_pkg::TPC_ADDR)) begin
      oe_reg <= 1'b1;
    end else if (byte_done && (state_reg == tpc_pkg::TPC_WR_BYTE)) begin
      oe_reg <= 1'b1;
    end else if (scl_fall && (state_reg == tpc_pkg::TPC_RD_BYTE)) begin
      tx_reg <= {tx_reg[6:0], 1'b1};
      oe_reg <= !tx_reg[6];
    end else if (scl_fall) begin
      oe_reg <= 1'b0;
    end
  end

  // channel settings written through the location access path
  always_ff @(posedge i_core_clk) begin
    if (rst_int) begin
      for (int c = 0; c < NCH; c++) begin
        en_reg[c]  <= tpc_pkg::RST_EN;
        div_reg[c] <= tpc_pkg::RST_DIV;
        per_reg[c] <= tpc_pkg::RST_PERIOD;
        wid_reg[c] <= tpc_pkg::RST_WIDTH;
      end
    end else if (wr_cfg && (wr_ch < NCH)) begin
      case (wr_fld)
        tpc_pkg::LOC_CTRL: begin
          en_reg[wr_ch]  <= shift_reg[tpc_pkg::CTRL_EN_BIT];
          div_reg[wr_ch] <= shift_reg[tpc_pkg::CTRL_DIV_LSB +: 2];
        end
        tpc_pkg::LOC_PERIOD:   per_reg[wr_ch] <= shift_reg;
        tpc_pkg::LOC_WIDTH_LO: wid_reg[wr_ch][7:0] <= shift_reg;
        default:               wid_reg[wr_ch][9:8] <= shift_reg[1:0];
      endcase
    end
  end

  // attention: raised by reset and by settings taking effect on a channel enabled before
  // or after the change, dropped on a status read; a new event in the clearing cycle keeps it raised
  always_ff @(posedge i_core_clk) begin
    if (rst_int) begin
      attn_reg <= 1'b1;
    end else if (|applied) begin
      attn_reg <= 1'b1;
    end else if (stat_read) begin
      attn_reg <= 1'b0;
    end
  end

  // only three channels are built; the fourth slot's pins carry the bus
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    tpc_pwm_chan u_chan (
      .i_core_clk (i_core_clk),
      .i_rst      (rst_int),
      .i_en       (en_reg[c]),
      .i_div      (div_reg[c]),
      .i_period   (per_reg[c]),
      .i_width    (wid_reg[c]),
      .o_pwm      (o_pwm[c]),
      .o_applied  (applied[c])
    );
  end

  // program memory shares the same serial path as the settings
  tpc_mem u_mem (
    .i_core_clk (i_core_clk),
    .i_we       (wr_mem),
    .i_addr     (ptr_reg[tpc_pkg::MEM_AW-1:0]),
    .i_wdata    (shift_reg),
    .o_rdata    (mem_q)
  );

  assign o_sda      = 1'b0;
  assign o_sda_oe   = oe_reg;
  assign o_attn_n   = !attn_reg;
  assign o_led_attn = attn_reg;
  assign o_led_rst  = !i_copro_rst_n;
  assign o_led_scl  = !i_scl;
  assign o_led_sda  = !i_sda;
endmodule

// ==== logic/tpc_pkg.sv ====
package tpc_pkg;
  // channel count: the fourth hardware slot shares pins with the serial bus
  localparam int unsigned HW_CHANNELS   = 4;
  localparam int unsigned NUM_CHANNELS  = HW_CHANNELS - 1;

  // serial target address, an arbitrary default
  localparam logic [6:0]  TARGET_ADDR   = 7'h2c;

  // location map: four bytes per channel, then status, then program memory
  localparam logic [7:0]  LOC_CH_STRIDE = 8'h04;
  localparam logic [1:0]  LOC_CTRL      = 2'h0;
  localparam logic [1:0]  LOC_PERIOD    = 2'h1;
  localparam logic [1:0]  LOC_WIDTH_LO  = 2'h2;
  localparam logic [1:0]  LOC_WIDTH_HI  = 2'h3;
  localparam logic [7:0]  LOC_STATUS    = 8'h0c;
  localparam logic [7:0]  LOC_MEM_BASE  = 8'h10;
  localparam int unsigned MEM_DEPTH     = 16;
  localparam int unsigned MEM_AW        = 4;

  // control byte fields
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_DIV_LSB  = 1;

  // status byte fields
  localparam int unsigned STAT_ATTN_BIT = 0;
  localparam int unsigned STAT_OUT_LSB  = 1;

  // reset values
  localparam logic        RST_EN        = 1'b0;
  localparam logic [1:0]  RST_DIV       = 2'h0;
  localparam logic [7:0]  RST_PERIOD    = 8'hff;
  localparam logic [9:0]  RST_WIDTH     = 10'h1ff;

  // base clock prescale terminal counts: /1, /4, /16, /64
  localparam logic [5:0]  PRE_LAST_D1   = 6'h00;
  localparam logic [5:0]  PRE_LAST_D4   = 6'h03;
  localparam logic [5:0]  PRE_LAST_D16  = 6'h0f;
  localparam logic [5:0]  PRE_LAST_D64  = 6'h3f;

  typedef enum logic [6:0] {
    TPC_IDLE     = 7'b0000001,
    TPC_ADDR     = 7'b0000010,
    TPC_ADDR_ACK = 7'b0000100,
    TPC_WR_BYTE  = 7'b0001000,
    TPC_WR_ACK   = 7'b0010000,
    TPC_RD_BYTE  = 7'b0100000,
    TPC_RD_ACK   = 7'b1000000
  } tpc_state_t;
endpackage

// ==== logic/tpc_mem.sv ====
`timescale 1ns/1ns
module tpc_mem (
  input  wire logic       i_core_clk,
  input  wire logic       i_we,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem_reg [tpc_pkg::MEM_DEPTH];

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem_reg[i_addr] <= i_wdata;
    end
    o_rdata <= mem_reg[i_addr];
  end
endmodule

// ==== logic/tpc_pwm_chan.sv ====
`timescale 1ns/1ns
module tpc_pwm_chan (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_en,
  input  wire logic [1:0] i_div,
  input  wire logic [7:0] i_period,
  input  wire logic [9:0] i_width,
  output logic            o_pwm,
  output logic            o_applied
);
  logic [5:0] pre_reg;
  logic [9:0] cnt_reg;
  logic [1:0] div_reg;
  logic [7:0] per_reg;
  logic [9:0] wid_reg;
  logic       en_reg;
  logic       pwm_reg;
  logic       applied_reg;

  function automatic logic [5:0] pre_last(input logic [1:0] div);
    case (div)
      2'h0:    pre_last = tpc_pkg::PRE_LAST_D1;
      2'h1:    pre_last = tpc_pkg::PRE_LAST_D4;
      2'h2:    pre_last = tpc_pkg::PRE_LAST_D16;
      default: pre_last = tpc_pkg::PRE_LAST_D64;
    endcase
  endfunction

  wire       tick     = (pre_reg == pre_last(div_reg));
  // period is always a multiple of four base cycles: the low bits are fixed
  wire [9:0] cnt_last = {per_reg, 2'b11};
  wire       wrap     = tick && (cnt_reg == cnt_last);
  // settings take effect at a period boundary, or at once while disabled, so no runt pulse appears
  wire       load     = wrap || !en_reg;
  wire       changed  = (i_en != en_reg) || (i_div != div_reg) ||
                        (i_period != per_reg) || (i_width != wid_reg);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pre_reg <= 6'h00;
    end else if (tick || !en_reg) begin
      pre_reg <= 6'h00;
    end else begin
      pre_reg <= pre_reg + 6'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || load) begin
      cnt_reg <= 10'h000;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 10'h001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      en_reg  <= tpc_pkg::RST_EN;
      div_reg <= tpc_pkg::RST_DIV;
      per_reg <= tpc_pkg::RST_PERIOD;
      wid_reg <= tpc_pkg::RST_WIDTH;
    end else if (load) begin
      en_reg  <= i_en;
      div_reg <= i_div;
      per_reg <= i_period;
      wid_reg <= i_width;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pwm_reg     <= 1'b0;
      applied_reg <= 1'b0;
    end else begin
      // width code w means w+1 active cycles; w past the period keeps it high
      pwm_reg     <= en_reg && (cnt_reg <= wid_reg);
      applied_reg <= load && changed && (en_reg || i_en);
    end
  end

  assign o_pwm     = pwm_reg;
  assign o_applied = applied_reg;
endmodule

// ==== bench/tpc_properties.sv ====
`timescale 1ns/1ns
module tpc_properties (
  input wire logic                        i_core_clk,
  input wire logic                        i_rst,
  input wire logic                        i_copro_rst_n,
  input wire logic                        i_scl,
  input wire logic                        i_sda,
  input wire logic                        o_sda,
  input wire logic                        o_sda_oe,
  input wire logic                        o_attn_n,
  input wire logic                        o_led_attn,
  input wire logic                        o_led_rst,
  input wire logic                        o_led_scl,
  input wire logic                        o_led_sda,
  input wire logic [tpc_pkg::NUM_CHANNELS-1:0] o_pwm
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  chk_led_reset_pin: assert property (o_led_rst == !i_copro_rst_n)
    else $error("reset lamp does not follow the reset pin");
  chk_reset_quiet: assert property (!i_copro_rst_n |=> (o_pwm == '0 && !o_attn_n && !o_sda_oe))
    else $error("outputs not quiet during pin reset");
  chk_attn_after_reset: assert property (!i_copro_rst_n ##1 i_copro_rst_n |-> !o_attn_n)
    else $error("attention not raised after reset");
  chk_attn_lamp_on: assert property (o_led_attn == !o_attn_n)
    else $error("attention lamp does not follow the attention line");
  chk_sda_open_drain: assert property (o_sda_oe |-> o_sda == 1'b0)
    else $error("data line driven high");
  chk_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data line changed while serial clock high");
  chk_scl_lamp: assert property (o_led_scl == !i_scl)
    else $error("clock lamp does not follow the clock line");
  chk_sda_lamp: assert property (o_led_sda == !i_sda)
    else $error("data lamp does not follow the data line");
  chk_attn_clear_bus: assert property ($rose(o_attn_n) |-> !i_scl && !$past(i_scl))
    else $error("attention cleared outside a byte load");
endmodule

// ==== bench/tpc_host_model.sv ====
`timescale 1ns/1ns
module tpc_host_model (
  input  wire logic i_core_clk,
  input  wire logic i_dev_oe,
  input  wire logic i_dev_sda,
  output logic      o_scl,
  output logic      o_sda
);
  logic scl_reg;
  logic pull_reg;

  initial begin
    scl_reg = 1'b1;
    pull_reg = 1'b0;
  end

  // the line has a pull-up, so a released line reads high
  assign o_sda = ~(pull_reg | (i_dev_oe & ~i_dev_sda));
  assign o_scl = scl_reg;

  // four core clocks a phase keeps each clock level above the three-clock minimum
  task automatic half;
    repeat (4) @(posedge i_core_clk);
  endtask

  task automatic bus_start;
    half; pull_reg <= 1'b0; half; scl_reg <= 1'b1; half; pull_reg <= 1'b1; half; scl_reg <= 1'b0;
  endtask

  task automatic bus_stop;
    half; pull_reg <= 1'b1; half; scl_reg <= 1'b1; half; pull_reg <= 1'b0;
  endtask

  task automatic bit_io(input logic b, output logic r);
    half; pull_reg <= ~b; half; scl_reg <= 1'b1; half; r = o_sda; scl_reg <= 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// ==== bench/tpc_top_bench.sv ====
`timescale 1ns/1ns
module tpc_top_bench;
  localparam int                         CEIL = 60000;
  localparam logic [7:0]                 ADDR_W = {tpc_pkg::TARGET_ADDR, 1'b0};
  logic                                  i_core_clk, i_rst, i_copro_rst_n;
  wire                                   scl, sda;
  logic                                  o_sda, o_sda_oe, o_attn_n, o_led_attn, o_led_rst, o_led_scl, o_led_sda;
  logic [tpc_pkg::NUM_CHANNELS-1:0]      o_pwm;
  int                                    mismatches, comparisons, cycles;
  logic [31:0]                           cfgs [4] = '{32'h00000001, 32'h00020103, 32'h01ffff01, 32'h00010007};
  int                                    chs [4] = '{0, 1, 2, 0};

  tpc_top dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_copro_rst_n(i_copro_rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_attn_n(o_attn_n), .o_led_attn(o_led_attn), .o_led_rst(o_led_rst),
    .o_led_scl(o_led_scl), .o_led_sda(o_led_sda), .o_pwm(o_pwm));
  tpc_host_model host (.i_core_clk(i_core_clk), .i_dev_oe(o_sda_oe), .i_dev_sda(o_sda), .o_scl(scl), .o_sda(sda));

  always #25 i_core_clk = ~i_core_clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles >= CEIL) begin
      mismatches++;
      tally_and_finish;
    end
  end

  task automatic open_at(input logic [7:0] ptr);
    logic ack;
    host.bus_start;
    host.wr_byte(ADDR_W, ack);
    check("address ack", ack, 1'b1);
    host.wr_byte(ptr, ack);
    check("pointer ack", ack, 1'b1);
  endtask

  task automatic write4(input logic [7:0] ptr, input logic [31:0] v);
    logic ack;
    open_at(ptr);
    for (int i = 0; i < 4; i++) begin
      host.wr_byte(v[8*i+:8], ack);
      check("data ack", ack, 1'b1);
    end
    host.bus_stop;
  endtask

  task automatic read4(input logic [7:0] ptr, output logic [31:0] v);
    logic       ack;
    logic [7:0] b;
    open_at(ptr);
    host.bus_start;
    host.wr_byte(ADDR_W | 8'h01, ack);
    check("read address ack", ack, 1'b1);
    for (int i = 0; i < 4; i++) begin
      host.rd_byte(i == 3, b);
      v[8*i+:8] = b;
    end
    host.bus_stop;
  endtask

  // skips one whole period so a setting change in flight never skews the counts
  task automatic measure(input int ch, output int hi, output int lo);
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    repeat (2) begin
      while (o_pwm[ch] !== 1'b0 && n < 5000) begin @(negedge i_core_clk); n++; end
      while (o_pwm[ch] !== 1'b1 && n < 5000) begin @(negedge i_core_clk); n++; end
    end
    while (o_pwm[ch] === 1'b1 && hi < 5000) begin @(negedge i_core_clk); hi++; end
    while (o_pwm[ch] === 1'b0 && lo < 5000) begin @(negedge i_core_clk); lo++; end
  endtask

  task automatic check_running(input int ch, input logic [31:0] cfg);
    int hi, lo, f, w, p;
    f = 1 << (2 * cfg[2:1]);
    w = (int'(cfg[25:16]) + 1) * f;
    p = (int'(cfg[15:8]) + 1) * 4 * f;
    measure(ch, hi, lo);
    check("high time", hi, w);
    check("low time", lo, p - w);
  endtask

  task automatic t_saturate;
    int lows;
    lows = 0;
    // short period so the width byte lands before the check window opens
    write4(8'h04, 32'h00070005);
    repeat (100) @(negedge i_core_clk);
    repeat (200) begin
      @(negedge i_core_clk);
      if (o_pwm[1] !== 1'b1) lows++;
    end
    check("saturated low count", lows, 0);
  endtask

  task automatic t_memory;
    logic [31:0] v;
    write4(8'h0d, 32'h11223344);
    write4(tpc_pkg::LOC_MEM_BASE + 8'h0c, 32'hc35aa53c);
    read4(tpc_pkg::LOC_MEM_BASE + 8'h0c, v);
    check("program memory", v, 32'hc35aa53c);
    read4(tpc_pkg::LOC_MEM_BASE, v);
    check("memory past unmapped write", v[7:0], 8'h11);
  endtask

  task automatic t_status(input logic exp_attn);
    logic [31:0] v;
    read4(tpc_pkg::LOC_STATUS, v);
    check("attention flag", v[0], exp_attn);
    check("unmapped reads", v[31:8], 24'h0);
    @(negedge i_core_clk);
    check("attention line", o_attn_n, 1'b1);
  endtask

  task automatic t_bad_addr;
    logic ack;
    host.bus_start;
    host.wr_byte(ADDR_W ^ 8'h02, ack);
    check("foreign address ack", ack, 1'b0);
    host.wr_byte(8'h00, ack);
    check("ignored byte ack", ack, 1'b0);
    host.bus_stop;
  endtask

  task automatic t_pin_reset;
    logic [31:0] v;
    @(posedge i_core_clk) i_copro_rst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    @(negedge i_core_clk);
    check("reset lamp", o_led_rst, 1'b1);
    check("outputs in pin reset", {o_pwm, o_attn_n, o_sda_oe}, 0);
    @(posedge i_core_clk) i_copro_rst_n <= 1'b1;
    read4(8'h08, v);
    check("channel defaults", v, 32'h01ffff00);
    check("disabled output", o_pwm, 0);
  endtask

  initial begin
    i_core_clk = 1'b0;
    i_rst = 1'b1;
    i_copro_rst_n = 1'b1;
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    repeat (3) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    @(negedge i_core_clk);
    check("outputs after reset", {o_pwm, o_attn_n, o_led_attn, o_sda_oe}, 5'b00010);
    check("channel count", $bits(o_pwm), 3);
    t_status(1'b1);
    for (int i = 0; i < 4; i++) begin
      write4(8'(4 * chs[i]), cfgs[i]);
      check_running(chs[i], cfgs[i]);
    end
    check_running(1, cfgs[1]);
    check_running(2, cfgs[2]);
    t_saturate;
    t_memory;
    t_status(1'b1);
    t_status(1'b0);
    t_bad_addr;
    t_pin_reset;
    tally_and_finish;
  end
endmodule

bind tpc_top tpc_properties chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_copro_rst_n(i_copro_rst_n),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_attn_n(o_attn_n), .o_led_attn(o_led_attn),
  .o_led_rst(o_led_rst), .o_led_scl(o_led_scl), .o_led_sda(o_led_sda), .o_pwm(o_pwm));
